// file: rtl/hcd_pkg.sv
package hcd_pkg;
	// Clock of the control logic
	localparam int CLK_PERIOD_NS    = 20;

	// Internal oscillator range, switching frequency in kHz
	localparam int OSC_MIN_FREQ_KHZ = 100;
	localparam int OSC_MAX_FREQ_KHZ = 1000;

	// Half switching period in clock cycles: toggle rate is twice the switching rate
	localparam int OSC_HALF_MAX_CYC = 1000000 / (OSC_MIN_FREQ_KHZ * CLK_PERIOD_NS * 2);
	localparam int OSC_HALF_MIN_CYC = 1000000 / (OSC_MAX_FREQ_KHZ * CLK_PERIOD_NS * 2);
	localparam int HALF_W           = 9;

	// Watchdog limit: a longest time, so it rounds down
	localparam int WDOG_TIMEOUT_NS  = 55000;
	localparam int WDOG_CYC         = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int WDOG_W           = 12;

	// Crossover dead time: a least time, so it rounds up
	localparam int DEAD_TIME_NS     = 20;
	localparam int DEAD_CYC         = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_W           = 4;

	// Bridge run state
	typedef enum logic {
		HCD_HOLD,
		HCD_RUN
	} hcd_state_e;
endpackage : hcd_pkg

// file: rtl/hcd_bridge_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module hcd_bridge_ctrl #(
	parameter int HALF_W_P = hcd_pkg::HALF_W,
	parameter int WDOG_W_P = hcd_pkg::WDOG_W
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                mode_internal,
	input  wire logic                clock_or_rate_resistor_pin,
	input  wire logic                rate_resistor_fitted,
	input  wire logic [HALF_W_P-1:0] rate_half_period,
	input  wire logic                supply_low,
	input  wire logic                over_temp,
	output logic                     bridge_drive_out_a,
	output logic                     bridge_drive_out_b,
	output logic                     bridge_running
);
	import hcd_pkg::*;

	localparam logic [HALF_W_P-1:0] HALF_MAX = HALF_W_P'(OSC_HALF_MAX_CYC);
	localparam logic [HALF_W_P-1:0] HALF_MIN = HALF_W_P'(OSC_HALF_MIN_CYC);
	localparam logic [WDOG_W_P-1:0] WDOG_LIM = WDOG_W_P'(WDOG_CYC);
	localparam logic [DEAD_W-1:0]   DEAD_LD  = DEAD_W'(DEAD_CYC);

	hcd_state_e          state_reg;
	hcd_state_e          state_next;
	logic [HALF_W_P-1:0] osc_cnt_reg;
	logic [WDOG_W_P-1:0] wdog_cnt_reg;
	logic [DEAD_W-1:0]   dead_reg;
	logic                phase_reg;
	logic                pin_d_reg;
	logic                uv_meta_reg;
	logic                uv_sync_reg;
	logic                ot_meta_reg;
	logic                ot_sync_reg;

	wire logic                fault;
	wire logic                pin_rise;
	wire logic                pin_change;
	wire logic [HALF_W_P-1:0] half_sel;
	wire logic                osc_tick;
	wire logic                toggle;
	wire logic                stall;
	wire logic                drive_ok;
	wire logic                dead_idle;

	// Resistor sets the rate; clamp to the usable band
	assign half_sel   = !rate_resistor_fitted ? HALF_MAX :
	                    (rate_half_period > HALF_MAX) ? HALF_MAX :
	                    (rate_half_period < HALF_MIN) ? HALF_MIN : rate_half_period;
	assign osc_tick   = osc_cnt_reg >= half_sel - HALF_W_P'(1);
	assign pin_rise   = clock_or_rate_resistor_pin && !pin_d_reg;
	assign pin_change = clock_or_rate_resistor_pin != pin_d_reg;
	// Source select; the toggle stage sees only one edge kind
	assign toggle     = mode_internal ? osc_tick : pin_rise;
	// Two register stages follow the stall, so stop two counts short
	// of the limit to keep the disable inside the longest allowed time
	assign stall      = wdog_cnt_reg == WDOG_LIM - WDOG_W_P'(2);
	// Faults win over whichever source is running
	assign fault      = uv_sync_reg || ot_sync_reg;
	assign drive_ok   = (state_reg == HCD_RUN) && !fault;
	assign dead_idle  = dead_reg == '0;

	// Run state: stall or fault stops, mode high or a rising edge restarts
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HCD_RUN: begin
				if (fault || (!mode_internal && stall))
					state_next = HCD_HOLD;
			end
			HCD_HOLD: begin
				if (!fault && (mode_internal || pin_rise))
					state_next = HCD_RUN;
			end
		endcase
	end

	// Two-flop synchronisers for the analogue fault flags
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			uv_meta_reg <= 1'b1;
			uv_sync_reg <= 1'b1;
			ot_meta_reg <= 1'b0;
			ot_sync_reg <= 1'b0;
		end else begin
			uv_meta_reg <= supply_low;
			uv_sync_reg <= uv_meta_reg;
			ot_meta_reg <= over_temp;
			ot_sync_reg <= ot_meta_reg;
		end
	end

	// Oscillator divider, restarts when the external source is in use
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			osc_cnt_reg <= '0;
		else if (!mode_internal || osc_tick)
			osc_cnt_reg <= '0;
		else
			osc_cnt_reg <= osc_cnt_reg + HALF_W_P'(1);
	end

	// Watchdog: held clear in internal mode so a mode fall starts the count
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_cnt_reg <= '0;
			pin_d_reg    <= 1'b0;
		end else begin
			pin_d_reg <= clock_or_rate_resistor_pin;
			if (mode_internal || pin_change)
				wdog_cnt_reg <= '0;
			else if (!stall)
				wdog_cnt_reg <= wdog_cnt_reg + WDOG_W_P'(1);
		end
	end

	// Divide-by-two stage; each toggle opens a dead gap in both halves
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 1'b0;
			dead_reg  <= '0;
			state_reg <= HCD_HOLD;
		end else begin
			state_reg <= state_next;
			if (toggle) begin
				phase_reg <= !phase_reg;
				dead_reg  <= DEAD_LD;
			end else if (dead_reg != '0) begin
				dead_reg  <= dead_reg - DEAD_W'(1);
			end
		end
	end

	// Equal gaps on both edges keep the duty exactly balanced
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bridge_drive_out_a <= 1'b0;
			bridge_drive_out_b <= 1'b0;
			bridge_running     <= 1'b0;
		end else begin
			bridge_drive_out_a <= drive_ok && phase_reg && (dead_reg == '0);
			bridge_drive_out_b <= drive_ok && !phase_reg && (dead_reg == '0);
			bridge_running     <= drive_ok;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence fault_held_s;
		over_temp [*3];
	endsequence

	sequence stall_seen_s;
		!mode_internal && stall && (state_reg == HCD_RUN);
	endsequence

	no_overlap_a: assert property (!(bridge_drive_out_a && bridge_drive_out_b))
		else $error("both bridge halves on");
	dead_gap_a: assert property ($rose(bridge_drive_out_b) |-> !$past(bridge_drive_out_a))
		else $error("half b on without dead gap");
	fault_off_a: assert property (fault |=> !bridge_drive_out_a && !bridge_drive_out_b)
		else $error("bridge driven during fault");
	hot_stop_a: assert property (fault_held_s |=> ##1 !bridge_running)
		else $error("overtemperature did not stop bridge");
	wdog_stop_a: assert property (stall_seen_s |=> (state_reg == HCD_HOLD) ##1 !bridge_running)
		else $error("stalled clock did not stop bridge");
	edge_restart_a: assert property ((state_reg == HCD_HOLD) && !mode_internal && pin_rise && !fault
		|=> state_reg == HCD_RUN)
		else $error("no restart on rising edge");
	mode_resume_a: assert property ((state_reg == HCD_HOLD) && mode_internal && !fault
		|=> state_reg == HCD_RUN ##1 (bridge_running || $past(fault)))
		else $error("no resume on mode high");
	rise_only_a: assert property (!$past(mode_internal) && $changed(phase_reg)
		|-> $past(pin_rise))
		else $error("phase moved without rising edge");
	default_rate_a: assert property (!rate_resistor_fitted |-> half_sel == HALF_MAX)
		else $error("default rate not minimum");
	osc_band_a: assert property (half_sel >= HALF_MIN && half_sel <= HALF_MAX)
		else $error("oscillator outside band");
	mode_fall_a: assert property ($fell(mode_internal) |-> wdog_cnt_reg == '0)
		else $error("watchdog not armed at mode fall");

	// Phase steps: external rises in one mode, oscillator ticks in the other
	sequence ext_rise_s;
		!mode_internal && pin_rise;
	endsequence

	sequence int_idle_s;
		mode_internal && !osc_tick;
	endsequence

	ext_toggle_a: assert property (ext_rise_s |=> $changed(phase_reg))
		else $error("external rise did not toggle phase");
	int_hold_a: assert property (int_idle_s |=> $stable(phase_reg))
		else $error("phase moved between oscillator ticks");
	compl_phase_a: assert property ($past(drive_ok) && $past(dead_idle)
		|-> bridge_drive_out_a != bridge_drive_out_b)
		else $error("bridge halves not complementary");
	hold_off_a: assert property ((state_reg == HCD_HOLD) |=> !bridge_drive_out_a && !bridge_drive_out_b)
		else $error("bridge driven while held");
	uv_hold_a: assert property (uv_sync_reg |=> !bridge_running)
		else $error("bridge ran during undervoltage");
	wdog_cap_a: assert property (wdog_cnt_reg <= WDOG_LIM)
		else $error("watchdog count past limit");
endmodule : hcd_bridge_ctrl

`default_nettype wire

// file: tb/hcd_clk_src.sv
`timescale 1ns/1ns
`default_nettype none
// External clock source; a stall holds the last level
module hcd_clk_src (
	input  wire logic sys_clk,
	input  wire logic run,
	output logic      pin
);
	logic [3:0] cnt_reg;
	initial begin
		cnt_reg = 4'h0;
		pin = 1'b0;
	end
	// Toggle every ten clocks, off the sampling edge
	always @(negedge sys_clk) begin
		if (run) begin
			cnt_reg <= (cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
			if (cnt_reg == 4'h9) pin <= ~pin;
		end
	end
endmodule : hcd_clk_src
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import hcd_pkg::*;
	logic              sys_clk = 1'b0, rst_n = 1'b0, mode = 1'b1, fit = 1'b1;
	logic              uv = 1'b0, ot = 1'b0, run = 1'b0;
	logic [HALF_W-1:0] half = 9'h019;
	wire logic         pin, out_a, out_b, on;
	int                fail_count = 0, comparisons = 0, n;
	hcd_clk_src src_u (.sys_clk(sys_clk), .run(run), .pin(pin));
	hcd_bridge_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .mode_internal(mode),
		.clock_or_rate_resistor_pin(pin), .rate_resistor_fitted(fit),
		.rate_half_period(half), .supply_low(uv), .over_temp(ot),
		.bridge_drive_out_a(out_a), .bridge_drive_out_b(out_b), .bridge_running(on));
	initial forever #10 sys_clk = ~sys_clk;
	task automatic check_bit(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : check_bit
	task automatic check_cnt(input int got, input int exp, input string m);
		comparisons++;
		if (got != exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %0d", $time, m, got);
		end
	endtask : check_cnt
	// Second pulse only, the first may be cut short by a rate change
	task automatic pulse(input logic sel, output int c);
		repeat (2) begin
			c = 0;
			repeat (600) if ((sel ? out_b : out_a) === 1'b1) @(negedge sys_clk);
			repeat (600) if ((sel ? out_b : out_a) !== 1'b1) @(negedge sys_clk);
			while ((sel ? out_b : out_a) === 1'b1 && c < 600) begin
				@(negedge sys_clk);
				c++;
			end
		end
	endtask : pulse
	task automatic wait_on(input logic exp, input int limit);
		repeat (limit) if (on !== exp) @(negedge sys_clk);
		check_bit(on, exp, "running state");
	endtask : wait_on
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	// Both halves on together would short the supply
	always @(negedge sys_clk) if (rst_n) check_bit(out_a & out_b, 1'b0, "overlap");
	task automatic t_internal;
		wait_on(1'b1, 10);
		pulse(1'b0, n); check_cnt(n, 24, "half a");
		pulse(1'b1, n); check_cnt(n, 24, "half b");
		half = 9'h1ff;
		pulse(1'b0, n); check_cnt(n, OSC_HALF_MAX_CYC - DEAD_CYC, "clamp high");
		half = 9'h003;
		pulse(1'b1, n); check_cnt(n, OSC_HALF_MIN_CYC - DEAD_CYC, "clamp low");
		half = 9'h064;
		pulse(1'b0, n); check_cnt(n, 100 - DEAD_CYC, "mid band");
		half = 9'h019;
		fit = 1'b0;
		pulse(1'b0, n); check_cnt(n, 249, "default rate");
		fit = 1'b1;
		mode = 1'b0;
		wait_on(1'b0, WDOG_CYC);
		check_bit(out_a | out_b, 1'b0, "outputs off");
		mode = 1'b1;
		wait_on(1'b1, 5);
		$display("internal mode done");
	endtask : t_internal
	task automatic t_external;
		mode = 1'b0;
		run <= 1'b1;
		pulse(1'b0, n); check_cnt(n, 19, "ext half a");
		pulse(1'b1, n); check_cnt(n, 19, "ext half b");
		run <= 1'b0;
		repeat (WDOG_CYC - 20) @(negedge sys_clk);
		check_bit(on, 1'b1, "early stop");
		wait_on(1'b0, 40);
		run <= 1'b1;
		wait_on(1'b1, 25);
		$display("external mode done");
	endtask : t_external
	task automatic t_faults;
		for (int i = 0; i < 2; i++) begin
			if (i == 0) uv = 1'b1; else ot = 1'b1;
			repeat (3) @(negedge sys_clk);
			check_bit(on | out_a | out_b, 1'b0, "fault off");
			uv = 1'b0;
			ot = 1'b0;
			wait_on(1'b1, 30);
		end
		$display("faults done");
	endtask : t_faults
	initial begin
		repeat (10) @(negedge sys_clk);
		check_bit(on | out_a | out_b, 1'b0, "reset");
		rst_n = 1'b1;
		t_internal();
		t_external();
		t_faults();
		tally_and_finish();
	end
	// Whole run is under twenty thousand clocks
	initial begin
		#1000000;
		fail_count++;
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
